// File: omc_pkg.sv
package omc_pkg;
   // ------------------------------------------------------------
   // register map (word index times four gives the byte address)
   // ------------------------------------------------------------
   localparam logic [3:0] OMC_ADDR_MODE = 4'h0;
   localparam logic [3:0] OMC_ADDR_VBA = 4'h4;
   localparam logic [3:0] OMC_ADDR_CORE_INTERRUPT_PRIORITY = 4'h8;
   localparam logic [3:0] OMC_ADDR_PERIPHERAL_INTERRUPT_PRIORITY = 4'hc;
   // ------------------------------------------------------------
   // mode register fields
   // ------------------------------------------------------------
   localparam int OMC_CDP_LSB = 8;
   localparam int OMC_MS_BIT = 6;
   localparam int OMC_SD_BIT = 7;
   localparam int OMC_RSV_BIT = 5;
   localparam int OMC_EBD_BIT = 4;
   localparam logic [23:0] OMC_MODE_WMASK = 24'h0003df;
   localparam logic [1:0] OMC_CDP_RESET = 2'h3;
   localparam logic [1:0] OMC_CDP_STATUS = 2'h0;
   localparam logic [1:0] OMC_CDP_DMA_HI = 2'h1;
   localparam logic [1:0] OMC_CDP_EQUAL = 2'h2;
   localparam logic [1:0] OMC_CDP_CORE_HI = 2'h3;
   // ------------------------------------------------------------
   // vector table and timing
   // ------------------------------------------------------------
   localparam int OMC_VEC_ENTRIES = 256;
   localparam int OMC_LONG_DELAY = 131072;
   localparam int OMC_SHORT_DELAY = 16;
   localparam int OMC_MS_SETTLE = 6;
   typedef enum logic [2:0] {
      OMC_RUN = 3'h1,
      OMC_HALT = 3'h2,
      OMC_WAKE = 3'h4
   } omc_state_t;
endpackage

// File: omc_reg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface omc_reg_if;
   logic [23:0] mode;
   logic [23:0] vector_base_register;
   logic [23:0] core_interrupt_priority;
   logic [23:0] peripheral_interrupt_priority;
   modport owner (output mode, output vector_base_register, output core_interrupt_priority, output peripheral_interrupt_priority);
   modport user (input mode, input vector_base_register, input core_interrupt_priority, input peripheral_interrupt_priority);
endinterface
`default_nettype wire

// File: omc_wake_timer.sv
`timescale 1ns/1ns
`default_nettype none
module omc_wake_timer
   import omc_pkg::*;
#(
   parameter int LONG_DELAY = OMC_LONG_DELAY
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic halt_req,
   input wire logic wake_event,
   input wire logic short_delay,
   output logic core_run
);
   typedef struct packed {
      omc_state_t st;
      logic [17:0] cnt;
   } omc_wt_t;
   omc_wt_t s, next_s;
   always_comb begin
      next_s = s;
      case (s.st)
         OMC_RUN: begin
            if (halt_req) begin
               next_s.st = OMC_HALT;
            end
         end
         OMC_HALT: begin
            if (wake_event) begin
               next_s.st = OMC_WAKE;
               // long delay lets the internal clock settle
               next_s.cnt = short_delay ? 18'(OMC_SHORT_DELAY - 1) : 18'(LONG_DELAY - 1);
            end
         end
         OMC_WAKE: begin
            if (s.cnt == 18'h0) begin
               next_s.st = OMC_RUN;
            end else begin
               next_s.cnt = s.cnt - 18'h1;
            end
         end
         default: next_s.st = OMC_RUN;
      endcase
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{st: OMC_RUN, cnt: 18'h0};
      end else begin
         s <= next_s;
      end
   end
   assign core_run = (s.st == OMC_RUN);
   a_short_wake: assert property (@(posedge mclk) disable iff (!reset_n)
      (s.st == OMC_HALT && wake_event && short_delay)
      |=> !core_run [*8] ##1 !core_run [*8] ##1 core_run)
      else $error("short wake delay wrong");
   a_halt_holds: assert property (@(posedge mclk) disable iff (!reset_n)
      (s.st == OMC_HALT && !wake_event) |=> !core_run)
      else $error("halt left without wake");
   c_wake: cover property (@(posedge mclk) disable iff (!reset_n)
      s.st == OMC_WAKE ##1 core_run);
endmodule
`default_nettype wire

// File: omc_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
module omc_arbiter
   import omc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   omc_reg_if.user regs,
   input wire logic [1:0] core_priority_field,
   input wire logic [1:0] dma_chan_priority,
   input wire logic core_req,
   input wire logic dma_req,
   output logic core_grant,
   output logic dma_grant,
   output logic ext_bus_enable
);
   typedef struct packed {
      logic last_dma;
   } omc_arb_t;
   omc_arb_t s, next_s;
   logic [1:0] cdp;
   logic dma_wins;
   assign cdp = regs.mode[OMC_CDP_LSB +: 2];
   assign ext_bus_enable = !regs.mode[OMC_EBD_BIT];
   always_comb begin
      next_s = s;
      case (cdp)
         OMC_CDP_STATUS: dma_wins = dma_chan_priority > core_priority_field;
         OMC_CDP_DMA_HI: dma_wins = 1'b1;
         OMC_CDP_EQUAL: dma_wins = !s.last_dma;
         default: dma_wins = 1'b0;
      endcase
      core_grant = ext_bus_enable && core_req && !(dma_req && dma_wins);
      dma_grant = ext_bus_enable && dma_req && !(core_req && !dma_wins);
      if (dma_grant) next_s.last_dma = 1'b1;
      if (core_grant) next_s.last_dma = 1'b0;
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{last_dma: 1'b0};
      end else begin
         s <= next_s;
      end
   end
   a_ebd_blocks: assert property (@(posedge mclk) disable iff (!reset_n)
      regs.mode[OMC_EBD_BIT] |-> !core_grant && !dma_grant)
      else $error("grant while bus disabled");
   a_dma_first: assert property (@(posedge mclk) disable iff (!reset_n)
      (cdp == OMC_CDP_DMA_HI && ext_bus_enable && dma_req) |-> dma_grant && !core_grant)
      else $error("dma not first");
   a_core_first: assert property (@(posedge mclk) disable iff (!reset_n)
      (cdp == OMC_CDP_CORE_HI && ext_bus_enable && core_req) |-> core_grant && !dma_grant)
      else $error("core not first");
   c_equal: cover property (@(posedge mclk) disable iff (!reset_n)
      cdp == OMC_CDP_EQUAL && core_req && dma_req ##1 core_req && dma_req);
endmodule
`default_nettype wire

// File: omc_top.sv
`timescale 1ns/1ns
`default_nettype none
module omc_top
   import omc_pkg::*;
#(
   parameter int LONG_DELAY = OMC_LONG_DELAY,
   parameter int PROG_AW = 16,
   parameter int SWAP_WORDS = 1024
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic mode_select_pin_3,
   input wire logic mode_select_pin_2,
   input wire logic mode_select_pin_1,
   input wire logic mode_select_pin_0,
   input wire logic cache_enable_flag,
   input wire logic [1:0] core_priority_field,
   input wire logic [1:0] dma_chan_priority,
   input wire logic core_req,
   input wire logic dma_req,
   output logic core_grant,
   output logic dma_grant,
   output logic ext_bus_enable,
   input wire logic halt_req,
   input wire logic wake_event,
   output logic core_run,
   output logic memory_switch_bit,
   output logic switch_settled,
   input wire logic [PROG_AW-1:0] prog_addr,
   output logic prog_in_data_ram,
   input wire logic [7:0] int_vector,
   output logic [23:0] vector_addr
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [23:0] mode;
      logic [23:0] vector_base_register;
      logic [23:0] core_interrupt_priority;
      logic [23:0] peripheral_interrupt_priority;
      logic strap_pending;
      logic ack;
      logic [2:0] settle;
      logic [31:0] rdata;
      logic [23:0] vaddr;
   } omc_top_t;
   omc_top_t s, next_s;
   omc_reg_if regs ();
   logic [3:0] strap;
   logic wr_hit;
   assign strap = {mode_select_pin_3, mode_select_pin_2, mode_select_pin_1, mode_select_pin_0};
   // ------------------------------------------------------------
   // register bus, one wait state per access
   // ------------------------------------------------------------
   assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
   assign wr_hit = avs_write && s.ack;
   always_comb begin
      next_s = s;
      next_s.ack = (avs_read || avs_write) && !s.ack;
      if (s.strap_pending) begin
         // straps caught at the first edge after release, not in the reset term
         next_s.mode[3:0] = strap;
         next_s.strap_pending = 1'b0;
      end else if (wr_hit) begin
         case (avs_address)
            OMC_ADDR_MODE: begin
               // bit five masked off, so it always reads zero
               next_s.mode = avs_writedata[23:0] & OMC_MODE_WMASK;
               if (avs_writedata[OMC_MS_BIT] != s.mode[OMC_MS_BIT]) begin
                  next_s.settle = 3'(OMC_MS_SETTLE);
               end
            end
            OMC_ADDR_VBA: next_s.vector_base_register = avs_writedata[23:0];
            OMC_ADDR_CORE_INTERRUPT_PRIORITY: next_s.core_interrupt_priority = avs_writedata[23:0];
            OMC_ADDR_PERIPHERAL_INTERRUPT_PRIORITY: next_s.peripheral_interrupt_priority = avs_writedata[23:0];
            default: ;
         endcase
      end
      if (s.settle != 3'h0 && !(wr_hit && avs_address == OMC_ADDR_MODE)) begin
         next_s.settle = s.settle - 3'h1;
      end
      case (avs_address)
         OMC_ADDR_MODE: next_s.rdata = {8'h0, s.mode};
         OMC_ADDR_VBA: next_s.rdata = {8'h0, s.vector_base_register};
         OMC_ADDR_CORE_INTERRUPT_PRIORITY: next_s.rdata = {8'h0, s.core_interrupt_priority};
         OMC_ADDR_PERIPHERAL_INTERRUPT_PRIORITY: next_s.rdata = {8'h0, s.peripheral_interrupt_priority};
         default: next_s.rdata = 32'h0;
      endcase
      // entries are two words, so the table spans 256 locations
      next_s.vaddr = s.vector_base_register + {16'h0, int_vector[6:0], 1'b0};
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{mode: {14'h0, OMC_CDP_RESET, 8'h0}, vector_base_register: 24'h0, core_interrupt_priority: 24'h0, peripheral_interrupt_priority: 24'h0,
                strap_pending: 1'b1, ack: 1'b0, settle: 3'h0, rdata: 32'h0,
                vaddr: 24'h0};
      end else begin
         s <= next_s;
      end
   end
   assign avs_readdata = s.rdata;
   assign vector_addr = s.vaddr;
   assign regs.mode = s.mode;
   assign regs.vector_base_register = s.vector_base_register;
   assign regs.core_interrupt_priority = s.core_interrupt_priority;
   assign regs.peripheral_interrupt_priority = s.peripheral_interrupt_priority;
   // ------------------------------------------------------------
   // memory switch
   // ------------------------------------------------------------
   // cache fixed at top; switching only grows the low ram region
   assign memory_switch_bit = s.mode[OMC_MS_BIT];
   assign switch_settled = (s.settle == 3'h0);
   assign prog_in_data_ram = memory_switch_bit &&
      (prog_addr < PROG_AW'(SWAP_WORDS));
   // ------------------------------------------------------------
   // sub blocks
   // ------------------------------------------------------------
   omc_arbiter u_arb (
      .mclk(mclk),
      .reset_n(reset_n),
      .regs(regs),
      .core_priority_field(core_priority_field),
      .dma_chan_priority(dma_chan_priority),
      .core_req(core_req),
      .dma_req(dma_req),
      .core_grant(core_grant),
      .dma_grant(dma_grant),
      .ext_bus_enable(ext_bus_enable)
   );
   omc_wake_timer #(.LONG_DELAY(LONG_DELAY)) u_wake (
      .mclk(mclk),
      .reset_n(reset_n),
      .halt_req(halt_req),
      .wake_event(wake_event),
      .short_delay(s.mode[OMC_SD_BIT]),
      .core_run(core_run)
   );
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_strap_load: assert property (@(posedge mclk) disable iff (!reset_n)
      s.strap_pending |=> s.mode[3:0] == $past(strap))
      else $error("mode bits not from pins");
   a_rsv_zero: assert property (@(posedge mclk) disable iff (!reset_n)
      !s.mode[OMC_RSV_BIT])
      else $error("reserved bit set");
   a_mode_write: assert property (@(posedge mclk) disable iff (!reset_n)
      (wr_hit && avs_address == OMC_ADDR_MODE && !s.strap_pending)
      |=> s.mode[3:0] == $past(avs_writedata[3:0]))
      else $error("mode write lost");
   a_ebd_reset: assert property (@(posedge mclk) disable iff (!reset_n)
      s.strap_pending |-> ext_bus_enable)
      else $error("bus disabled after reset");
   a_wait_one: assert property (@(posedge mclk) disable iff (!reset_n)
      (avs_read && !s.ack) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer late");
   // software duty only; the flag is watched here so a misuse shows up
   a_switch_cache: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(memory_switch_bit) |-> !$past(cache_enable_flag))
      else $error("switch set with cache on");
   c_switch: cover property (@(posedge mclk) disable iff (!reset_n)
      !switch_settled ##1 switch_settled [*2]);
   c_strap: cover property (@(posedge mclk) disable iff (!reset_n)
      s.strap_pending ##1 s.mode[3:0] != 4'h0);
endmodule
`default_nettype wire

// File: omc_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import omc_pkg::*;
   // ------------------------------------------------------------
   // signals and table
   // ------------------------------------------------------------
   // short restart count keeps the long wake test to a few cycles
   localparam int LD = 64;
   typedef struct {logic [3:0] a; logic [23:0] w; logic [31:0] r;} omc_row_t;
   logic mclk = 0, reset_n = 0, avs_read = 0, avs_write = 0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic mode_select_pin_3 = 1, mode_select_pin_2 = 0;
   logic mode_select_pin_1 = 1, mode_select_pin_0 = 0;
   // cache flag held low: the switch must never be set while it is high
   logic cache_enable_flag = 0;
   logic [1:0] core_priority_field = 2'h0, dma_chan_priority = 2'h0;
   logic core_req = 0, dma_req = 0, halt_req = 0, wake_event = 0, g;
   logic [15:0] prog_addr = 16'h0;
   logic [7:0] int_vector = 8'h0;
   logic avs_waitrequest, core_grant, dma_grant, ext_bus_enable, core_run;
   logic memory_switch_bit, switch_settled, prog_in_data_ram;
   logic [23:0] vector_addr;
   int bad_count = 0, samples_checked = 0, cycles = 0;
   omc_row_t rows[7] = '{
      '{OMC_ADDR_MODE, 24'hffffff, 32'h0003df},
      '{OMC_ADDR_MODE, 24'h000020, 32'h000000},
      '{OMC_ADDR_VBA, 24'h123456, 32'h123456},
      '{OMC_ADDR_CORE_INTERRUPT_PRIORITY, 24'habcdef, 32'habcdef},
      '{OMC_ADDR_PERIPHERAL_INTERRUPT_PRIORITY, 24'h654321, 32'h654321},
      '{4'h1, 24'h111111, 32'h000000},
      '{OMC_ADDR_MODE, 24'h000010, 32'h000010}
   };
   omc_top #(.LONG_DELAY(LD)) dut (.mclk, .reset_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .mode_select_pin_3,
      .mode_select_pin_2, .mode_select_pin_1, .mode_select_pin_0, .cache_enable_flag,
      .core_priority_field, .dma_chan_priority, .core_req, .dma_req, .core_grant,
      .dma_grant, .ext_bus_enable, .halt_req, .wake_event, .core_run, .memory_switch_bit,
      .switch_settled, .prog_addr, .prog_in_data_ram, .int_vector, .vector_addr);
   always #10 mclk = ~mclk;
   // ------------------------------------------------------------
   // hang guard and report
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // ------------------------------------------------------------
   // bus cycles: request held until waitrequest is seen low
   // ------------------------------------------------------------
   task automatic bus(input logic wr_n_rd, input logic [3:0] a, input logic [23:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= wr_n_rd;
      avs_read <= !wr_n_rd;
      avs_writedata <= {8'h00, d};
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 50) bad_count++;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [23:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 24'h0);
      chk(q, exp);
   endtask
   task automatic wake(input logic sd, input int n);
      int k;
      k = 0;
      wr(OMC_ADDR_MODE, {16'h0000, sd, 7'h00});
      halt_req <= 1'b1;
      @(posedge mclk);
      halt_req <= 1'b0;
      repeat (20) @(posedge mclk);
      chk(core_run, 1'b0);
      wake_event <= 1'b1;
      @(posedge mclk);
      wake_event <= 1'b0;
      while (core_run !== 1'b1 && k < 200) begin
         @(posedge mclk);
         k++;
      end
      chk(k >= n && k <= n + 2, 1'b1);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge mclk);
      chk(ext_bus_enable, 1'b1);
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      rd(OMC_ADDR_MODE, 32'h00030a);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].r);
      end
      @(posedge mclk);
      chk(ext_bus_enable, 1'b0);
      wr(OMC_ADDR_MODE, 24'h000000);
      @(posedge mclk);
      chk(ext_bus_enable, 1'b1);
      // both sides ask at once so the ranking decides
      core_req <= 1'b1;
      dma_req <= 1'b1;
      core_priority_field <= 2'h1;
      dma_chan_priority <= 2'h3;
      @(posedge mclk);
      chk({core_grant, dma_grant}, 2'b01);
      core_priority_field <= 2'h2;
      dma_chan_priority <= 2'h2;
      @(posedge mclk);
      chk({core_grant, dma_grant}, 2'b10);
      wr(OMC_ADDR_MODE, 24'h000100);
      @(posedge mclk);
      chk({core_grant, dma_grant}, 2'b01);
      wr(OMC_ADDR_MODE, 24'h000300);
      @(posedge mclk);
      chk({core_grant, dma_grant}, 2'b10);
      wr(OMC_ADDR_MODE, 24'h000200);
      @(posedge mclk);
      g = core_grant;
      chk(core_grant ^ dma_grant, 1'b1);
      @(posedge mclk);
      chk(core_grant, !g);
      wr(OMC_ADDR_MODE, 24'h000040);
      @(posedge mclk);
      chk(memory_switch_bit, 1'b1);
      chk(switch_settled, 1'b0);
      chk(prog_in_data_ram, 1'b1);
      repeat (8) @(posedge mclk);
      chk(switch_settled, 1'b1);
      prog_addr <= 16'h0400;
      int_vector <= 8'h7f;
      repeat (3) @(posedge mclk);
      chk(prog_in_data_ram, 1'b0);
      chk(vector_addr, 32'h123554);
      wake(1'b1, OMC_SHORT_DELAY);
      wake(1'b0, LD);
      // second reset over a set disable bit, with other strap values
      wr(OMC_ADDR_MODE, 24'h000010);
      {mode_select_pin_3, mode_select_pin_2, mode_select_pin_1, mode_select_pin_0} <= 4'h5;
      reset_n <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(ext_bus_enable, 1'b1);
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      rd(OMC_ADDR_MODE, 32'h000305);
      end_of_test();
   end
endmodule
`default_nettype wire
